// ---- odf_defines.svh ----
// constants for the octal input debounce filter
// assumes a 25 MHz logic clock and field inputs already resolved to levels
// Overview of operation
// - inputs resolve to one when sensor on
// - open input reads as logic low
// - outputs undefined while supply lockout active
// - fast channels pass without debounce
// - slow channels always get fixed 4us filter
// - debounce delay adds after fixed filter
// - delay select 00/01/10/11 gives 0/10/30/100 ms
// - delay select 00 means zero limit
// - mode 00 deglitch, 01 low-pass, 1x blanking
// - parallel variant forces low-pass, fixed delay
// - deglitch adopts input after stable full time
// - deglitch drops changes that revert early
// - low-pass saturating counter up differ, down match
// - low-pass keeps partial count on toggle back
// - low-pass output switches when count hits limit
// - blanking follows change at once, then blind
// - blanking adopts differing input at count zero
// - two-bit fields, four channels per byte
`ifndef ODF_DEFINES_SVH
`define ODF_DEFINES_SVH
`define ODF_CLK_HZ 25000000
`define ODF_TICK_HZ 1000
`define ODF_TICK_CYC (`ODF_CLK_HZ / `ODF_TICK_HZ)
`define ODF_PRE_NS 4000
`define ODF_CLK_NS 40
`define ODF_PRE_CYC ((`ODF_PRE_NS + `ODF_CLK_NS - 1) / `ODF_CLK_NS)
`define ODF_DLY0_MS 0
`define ODF_DLY1_MS 10
`define ODF_DLY2_MS 30
`define ODF_DLY3_MS 100
`define ODF_ADDR_STATUS 3'h0
`define ODF_ADDR_MODE0 3'h1
`define ODF_ADDR_MODE1 3'h2
`define ODF_ADDR_DLY0 3'h3
`define ODF_ADDR_DLY1 3'h4
`define ODF_MODE_RST 8'h00
`define ODF_DLY_RST 8'h00
`endif

// ---- odf_pkg.sv ----
// types for the octal input debounce filter
// assumes odf_defines.svh supplies all numeric constants
package odf_pkg;
    typedef enum logic [1:0] {
        ODF_DEGLITCH = 2'h0,
        ODF_LOWPASS = 2'h1,
        ODF_BLANKING = 2'h3
    } odf_mode_t;
endpackage : odf_pkg

// ---- odf_filter.sv ----
// eight-channel debounce filter with plain register port
// assumes field inputs are asynchronous levels with pull-down at the pin
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "odf_defines.svh"
`timescale 1ns/1ps
module odf_filter #(
    parameter int NCH = 8,
    parameter int TICK_CYC = `ODF_TICK_CYC,
    parameter int PRE_CYC = `ODF_PRE_CYC,
    parameter bit PARALLEL_VARIANT = 1'b0,
    parameter logic [1:0] FIXED_DELAY = 2'h0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // field side
    input wire logic [NCH-1:0] slow_field_input,
    input wire logic [NCH-1:0] fast_field_input,
    input wire logic supply_lockout,
    // outputs
    output logic [NCH-1:0] slow_channel_output,
    output logic [NCH-1:0] fast_channel_output,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    localparam int CW = 7;
    localparam int PW = 8;
    localparam int TW = 16;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [NCH-1:0] slow_s1_q, slow_s2_q, fast_s1_q, fast_s2_q;
    always_ff @(posedge clk) begin
        slow_s1_q <= slow_field_input;
        slow_s2_q <= slow_s1_q;
        fast_s1_q <= fast_field_input;
        fast_s2_q <= fast_s1_q;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] mode0_q, mode1_q, dly0_q, dly1_q;
    wire wr_mode0 = reg_wr && reg_addr == `ODF_ADDR_MODE0;
    wire wr_mode1 = reg_wr && reg_addr == `ODF_ADDR_MODE1;
    wire wr_dly0 = reg_wr && reg_addr == `ODF_ADDR_DLY0;
    wire wr_dly1 = reg_wr && reg_addr == `ODF_ADDR_DLY1;
    always_ff @(posedge clk) begin
        if (rst) begin
            mode0_q <= `ODF_MODE_RST;
            mode1_q <= `ODF_MODE_RST;
            dly0_q <= `ODF_DLY_RST;
            dly1_q <= `ODF_DLY_RST;
        end else begin
            if (wr_mode0) mode0_q <= reg_wdata;
            if (wr_mode1) mode1_q <= reg_wdata;
            if (wr_dly0) dly0_q <= reg_wdata;
            if (wr_dly1) dly1_q <= reg_wdata;
        end
    end
    wire [15:0] mode_word = {mode1_q, mode0_q};
    wire [15:0] dly_word = {dly1_q, dly0_q};
    wire [7:0] rd_mux =
        reg_addr == `ODF_ADDR_STATUS ? slow_channel_output :
        reg_addr == `ODF_ADDR_MODE0 ? mode0_q :
        reg_addr == `ODF_ADDR_MODE1 ? mode1_q :
        reg_addr == `ODF_ADDR_DLY0 ? dly0_q :
        reg_addr == `ODF_ADDR_DLY1 ? dly1_q : 8'h00;
    always_ff @(posedge clk) begin
        if (rst) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= rd_mux;
        else reg_rdata <= 8'h00;
    end

    // ----------------------------------------
    // millisecond timebase
    // ----------------------------------------
    logic [TW-1:0] tick_cnt_q;
    logic tick_q;
    wire tick_wrap = tick_cnt_q == TW'(TICK_CYC - 1);
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
            tick_q <= tick_wrap;
        end
    end

    // ----------------------------------------
    // fast channels
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) fast_channel_output <= '0;
        else fast_channel_output <= fast_s2_q;
    end

    // ----------------------------------------
    // slow channels
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            logic [PW-1:0] pre_cnt_q;
            logic pre_out_q;
            logic [CW-1:0] cnt_q;
            logic out_q;
            logic [1:0] dsel, msel;
            logic [CW-1:0] lim;
            odf_pkg::odf_mode_t mode;
            // fixed saturating low-pass stage, always present
            wire pre_diff = slow_s2_q[i] != pre_out_q;
            wire pre_hit = pre_cnt_q == PW'(PRE_CYC - 1);
            always_ff @(posedge clk) begin
                if (rst) begin
                    pre_cnt_q <= '0;
                    pre_out_q <= 1'b0;
                end else if (pre_diff && pre_hit) begin
                    pre_cnt_q <= '0;
                    pre_out_q <= slow_s2_q[i];
                end else if (pre_diff) begin
                    pre_cnt_q <= pre_cnt_q + 1'b1;
                end else if (pre_cnt_q != '0) begin
                    pre_cnt_q <= pre_cnt_q - 1'b1;
                end
            end
            assign dsel = PARALLEL_VARIANT ? FIXED_DELAY : dly_word[2*i +: 2];
            assign msel = PARALLEL_VARIANT ? 2'h1 : mode_word[2*i +: 2];
            assign mode = msel[1] ? odf_pkg::ODF_BLANKING :
                          msel[0] ? odf_pkg::ODF_LOWPASS : odf_pkg::ODF_DEGLITCH;
            assign lim = dsel == 2'h0 ? CW'(`ODF_DLY0_MS) :
                         dsel == 2'h1 ? CW'(`ODF_DLY1_MS) :
                         dsel == 2'h2 ? CW'(`ODF_DLY2_MS) : CW'(`ODF_DLY3_MS);
            wire in = pre_out_q;
            wire diff = in != out_q;
            logic in_prev_q;
            wire chg = in != in_prev_q;
            always_ff @(posedge clk) begin
                if (rst) begin
                    cnt_q <= '0;
                    out_q <= 1'b0;
                    in_prev_q <= 1'b0;
                end else begin
                    in_prev_q <= in;
                    unique case (mode)
                        odf_pkg::ODF_DEGLITCH: begin
                            if (!diff || chg) cnt_q <= '0;
                            else if (cnt_q >= lim) begin
                                out_q <= in;
                                cnt_q <= '0;
                            end else if (tick_q) cnt_q <= cnt_q + 1'b1;
                        end
                        odf_pkg::ODF_LOWPASS: begin
                            if (diff && cnt_q >= lim) begin
                                out_q <= in;
                                cnt_q <= '0;
                            end else if (tick_q && diff) cnt_q <= cnt_q + 1'b1;
                            else if (tick_q && cnt_q != '0) cnt_q <= cnt_q - 1'b1;
                        end
                        odf_pkg::ODF_BLANKING: begin
                            if (cnt_q != '0) begin
                                if (tick_q) cnt_q <= cnt_q - 1'b1;
                            end else if (diff) begin
                                out_q <= in;
                                cnt_q <= lim;
                            end
                        end
                    endcase
                end
            end
            always_ff @(posedge clk) begin
                if (rst) slow_channel_output[i] <= 1'b0;
                else slow_channel_output[i] <= out_q;
            end
        end
    endgenerate
    wire unused_lockout = supply_lockout;
endmodule : odf_filter

// ---- odf_filter_monitor.sv ----
// assertions on the ports of the debounce filter
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module odf_filter_monitor #(parameter int NCH = 8) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // field side and outputs
    input wire logic [NCH-1:0] slow_field_input,
    input wire logic [NCH-1:0] fast_field_input,
    input wire logic [NCH-1:0] slow_channel_output,
    input wire logic [NCH-1:0] fast_channel_output,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // cycles the slow inputs have held still
    logic [11:0] stable_q;
    always_ff @(posedge clk) begin
        if (rst || $changed(slow_field_input)) stable_q <= 12'h000;
        else if (stable_q != 12'hFFF) stable_q <= stable_q + 12'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst_out; disable iff (1'b0) rst |=> slow_channel_output == '0 && fast_channel_output == '0; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not low after reset");
    property p_fast; !rst [*4] |-> fast_channel_output == $past(fast_field_input, 3); endproperty
    a_fast: assert property (p_fast) else $error("fast channel not a plain delay");
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rdback; reg_wr && reg_addr inside {[3'h1:3'h4]} ##1 reg_rd && reg_addr == $past(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 2); endproperty
    a_rdback: assert property (p_rdback) else $error("setting readback mismatch");
    property p_unmapped; reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reg_rst; $past(rst) && reg_rd && reg_addr inside {[3'h1:3'h4]} |=> reg_rdata == 8'h00; endproperty
    a_reg_rst: assert property (p_reg_rst) else $error("setting not zero after reset");
    property p_settle; stable_q >= 12'h4B0 |-> slow_channel_output == slow_field_input; endproperty
    a_settle: assert property (p_settle) else $error("slow output not settled");
    property p_hold; stable_q >= 12'h4B0 |=> $stable(slow_channel_output); endproperty
    a_hold: assert property (p_hold) else $error("slow output moved on still input");
    c_rdback: cover property (p_rdback);
    c_settle: cover property (p_settle);
    c_reg_rst: cover property (p_reg_rst);
endmodule : odf_filter_monitor
bind odf_filter odf_filter_monitor #(.NCH(NCH)) u_mon (.clk(clk), .rst(rst), .slow_field_input(slow_field_input),
    .fast_field_input(fast_field_input), .slow_channel_output(slow_channel_output),
    .fast_channel_output(fast_channel_output), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ---- odf_sensor_model.sv ----
// field sensors driving the slow and fast input lines
// assumes the bench commands slow levels; fast lines chatter when enabled
`timescale 1ns/1ps
module odf_sensor_model (
    // clock and commands
    input wire logic clk,
    input wire logic [7:0] slow_level,
    input wire logic fast_noise,
    // field lines
    output logic [7:0] slow_field_input = 8'h00,
    output logic [7:0] fast_field_input = 8'h00
);
    always @(posedge clk) begin
        slow_field_input <= slow_level;
        fast_field_input <= fast_noise ? 8'($urandom) : 8'h00;
    end
endmodule : odf_sensor_model

// ---- tb_top.sv ----
// self-checking bench for the debounce filter
// assumes shortened tick and prefilter counts set at the instance
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst = 1, noise = 0, wr = 0, rd = 0, rd_q = 0, smp = 0;
    logic [7:0] lvl = 8'h00, wd = 8'h00, s_in, f_in, s_out, rdata, exp_s = 8'h00;
    logic [7:0] f_out, f_d1, f_d2, f_d3;
    logic r1 = 1'b1;
    logic [2:0] ad = 3'h0;
    logic [7:0] regs [8];
    logic [7:0] exp_q [$];
    int error_cnt = 0, total_checks = 0, cyc = 0;
    always #20 clk = ~clk;
    odf_sensor_model sens (.clk(clk), .slow_level(lvl), .fast_noise(noise), .slow_field_input(s_in),
        .fast_field_input(f_in));
    odf_filter #(.TICK_CYC(10), .PRE_CYC(4)) uut (.clk(clk), .rst(rst), .slow_field_input(s_in),
        .fast_field_input(f_in), .supply_lockout(1'b0), .slow_channel_output(s_out), .fast_channel_output(f_out),
        .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] e, input string what);
        total_checks++;
        if (seen !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
        end
    endtask : check
    task automatic end_of_test;
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w; rd <= r; ad <= a; wd <= d;
        if (r) exp_q.push_back(a == 3'h0 ? exp_s : (a > 3'h4 ? 8'h00 : regs[a]));
        if (w && a != 3'h0 && a < 3'h5) regs[a] = d;
    endtask : bus
    task automatic sample(input int n, input logic [7:0] e);
        repeat (n) @(posedge clk);
        exp_q.push_back(e);
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
    endtask : sample
    // reset, then a setting read in the very first cycle after release
    task automatic do_reset;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0; rd <= 1'b1; ad <= 3'h1;
        regs = '{default: 8'h00};
        exp_s = 8'h00;
        exp_q.push_back(8'h00);
        bus(0, 0, 3'h0, 8'h00);
        sample(1, 8'h00);
    endtask : do_reset
    always @(posedge clk) begin
        rd_q <= rd;
        // fast path is two sync stages plus the output register
        f_d1 <= f_in;
        f_d2 <= f_d1;
        f_d3 <= f_d2;
        r1 <= rst;
        if (!r1 && noise) check(f_out, f_d3, "fast_channel_output");
        if (rd_q) check(rdata, exp_q.pop_front(), "reg_rdata");
        if (smp) check(s_out, exp_q.pop_front(), "slow_channel_output");
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(89));
        do_reset();
        noise <= 1'b1;
        bus(1, 0, 3'h0, 8'h5A);
        for (int a = 1; a < 5; a++) begin
            bus(1, 0, a[2:0], 8'($urandom));
            bus(0, 1, a[2:0], 8'h00);
        end
        for (int a = 0; a < 8; a++) bus(0, 1, a[2:0], 8'h00);
        // ch0 deglitch, ch1 low-pass, ch2/ch3 blanking; ch0-3 at 10 ms, ch4-7 at zero
        bus(1, 0, 3'h1, 8'hE4);
        bus(1, 0, 3'h2, 8'hE4);
        bus(1, 0, 3'h3, 8'h55);
        bus(1, 0, 3'h4, 8'h00);
        bus(0, 0, 3'h0, 8'h00);
        lvl <= 8'hFF;
        sample(18, 8'hFC);
        lvl <= 8'h00;
        sample(18, 8'h0C);
        sample(250, 8'h00);
        lvl <= 8'hFF;
        sample(1300, 8'hFF);
        exp_s = 8'hFF;
        bus(0, 1, 3'h0, 8'h00);
        bus(0, 0, 3'h0, 8'h00);
        do_reset();
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule : tb_top
